/* hdl/ief_consts.svh */
`ifndef IEF_CONSTS_SVH
`define IEF_CONSTS_SVH

// bus geometry: byte address, each register one aligned word, index = address / 4
`define IEF_ADDR_W        18
`define IEF_DATA_W        32
`define IEF_IDX_W         16
`define IEF_ADDR_LSB      2

// register indices
`define IEF_IDX_CLKSW_EN  16'hFF22
`define IEF_IDX_SER_EN    16'hFF23
`define IEF_IDX_KEY_EN    16'hFF24
`define IEF_IDX_TMR_EN    16'hFF25
`define IEF_IDX_CLKSW_FLG 16'hFF26
`define IEF_IDX_SER_FLG   16'hFF27
`define IEF_IDX_KEY_FLG   16'hFF28
`define IEF_IDX_TMR_FLG   16'hFF29

// implemented bits of each group; the rest read as zero
`define IEF_MASK_CLKSW    8'h7F
`define IEF_MASK_SER      8'h3F
`define IEF_MASK_KEY      8'hFF
`define IEF_MASK_TMR      8'hFF
`define IEF_RESET_VAL     8'h00

// clock timer and stopwatch group
`define IEF_BIT_CT1       0
`define IEF_BIT_CT2       1
`define IEF_BIT_CT8       2
`define IEF_BIT_CT32      3
`define IEF_BIT_SW1       4
`define IEF_BIT_SW10      5
`define IEF_BIT_SW100     6

// serial group
`define IEF_BIT_S0TX      0
`define IEF_BIT_S0RX      1
`define IEF_BIT_S0ERR     2
`define IEF_BIT_S1TX      3
`define IEF_BIT_S1RX      4
`define IEF_BIT_S1ERR     5

// number of source groups and of programmable timers covered
`define IEF_GROUPS        4
`define IEF_TIMERS        4

`endif

/* hdl/ief_pkg.sv */
package ief_pkg;

  typedef enum logic [1:0] {
    IEF_BUS_IDLE = 2'b01,
    IEF_BUS_ACK  = 2'b10
  } ief_bus_state_type;

  typedef struct packed {
    ief_bus_state_type state;
    logic [31:0]       readData;
  } ief_bus_struct_type;

  typedef struct packed {
    logic [7:0] flags;
  } ief_flag_struct_type;

  typedef struct packed {
    logic [3:0][7:0] enables;
    logic [3:0][7:0] irqReq;
    logic            anyIrq;
  } ief_core_struct_type;

endpackage

/* hdl/ief_flag_reg.sv */
module ief_flag_reg #(
  parameter logic [7:0] VALID_MASK = 8'hFF
) (
  input  wire logic       core_clk,
  input  wire logic       sys_rst,
  input  wire logic [7:0] setEvt,
  input  wire logic       clrStb,
  input  wire logic [7:0] clrData,
  output logic      [7:0] flags
);
  import ief_pkg::*;

  ief_flag_struct_type cur_ff;
  ief_flag_struct_type nxt_cur;

  always_comb begin
    nxt_cur = cur_ff;
    for (int i = 0; i < 8; i++) begin
      // an event in the clearing cycle survives: set beats clear
      if (!VALID_MASK[i]) begin
        nxt_cur.flags[i] = 1'b0;
      end else if (setEvt[i]) begin
        nxt_cur.flags[i] = 1'b1;
      end else if (clrStb && clrData[i]) begin
        nxt_cur.flags[i] = 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign flags = cur_ff.flags;

endmodule

/* hdl/ief_avmm_slave.sv */
module ief_avmm_slave (
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [3:0]  avs_byteenable,
  input  wire logic [7:0]  rdValue,
  output logic             avs_waitrequest,
  output logic      [31:0] avs_readdata,
  output logic             wrStb
);
  import ief_pkg::*;

  ief_bus_struct_type cur_ff;
  ief_bus_struct_type nxt_cur;

  always_comb begin
    nxt_cur = cur_ff;
    case (cur_ff.state)
      IEF_BUS_IDLE: begin
        if (avs_read || avs_write) begin
          nxt_cur.state = IEF_BUS_ACK;
        end
        if (avs_read) begin
          nxt_cur.readData = {24'h000000, rdValue};
        end
      end
      IEF_BUS_ACK: begin
        nxt_cur.state = IEF_BUS_IDLE;
      end
      default: begin
        nxt_cur.state = IEF_BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cur_ff <= '{state: IEF_BUS_IDLE, readData: 32'h00000000};
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  // one wait cycle, then a single acknowledge cycle
  assign avs_waitrequest = (cur_ff.state != IEF_BUS_ACK);
  assign avs_readdata    = cur_ff.readData;
  assign wrStb           = (cur_ff.state == IEF_BUS_ACK) && avs_write && avs_byteenable[0];

endmodule

/* hdl/ief_irq_enable_flag_bank.sv */
`include "ief_consts.svh"

// Operation
// - serial enable D3..D0: s1 tx, s0 err/rx/tx
// - key line n: enable and flag bit n
// - timer n: compare bit 2n+1, underflow 2n
// - enables read/write, 1 permits, reset zero
// - flag reads one once its event occurred
// - writing one clears flag, zero keeps it
// - clock timer flags 32/8/2/1 Hz in D3..D0
// - stopwatch flags 100/10/1 Hz in D6..D4
// - serial flags D5..D0, D7..D6 read zero
// - timer flags, timer 3 compare in D7
// - reset clears every factor flag
// - serial enable D5 s1 err, D4 s1 rx
module ief_irq_enable_flag_bank (
  input  wire logic                   core_clk,
  input  wire logic                   sys_rst,
  input  wire logic [`IEF_ADDR_W-1:0] avs_address,
  input  wire logic                   avs_read,
  input  wire logic                   avs_write,
  input  wire logic [31:0]            avs_writedata,
  input  wire logic [3:0]             avs_byteenable,
  output logic      [31:0]            avs_readdata,
  output logic                        avs_waitrequest,
  input  wire logic [3:0]             clkTimerEvt,
  input  wire logic [2:0]             stopwatchEvt,
  input  wire logic [2:0]             ser0Evt,
  input  wire logic [2:0]             ser1Evt,
  input  wire logic [7:0]             keyLineEvt,
  input  wire logic [3:0]             progTimerUflowEvt,
  input  wire logic [3:0]             progTimerCmpEvt,
  output logic      [7:0]             clkSwIrqReq,
  output logic      [7:0]             serialIrqReq,
  output logic      [7:0]             keyLineIrqReq,
  output logic      [7:0]             progTimerIrqReq,
  output logic                        anyIrqReq
);
  import ief_pkg::*;

  localparam logic [3:0][7:0] GROUP_MASK = {`IEF_MASK_TMR, `IEF_MASK_KEY,
                                            `IEF_MASK_SER, `IEF_MASK_CLKSW};

  ief_core_struct_type    cur_ff;
  ief_core_struct_type    nxt_cur;
  logic [3:0][7:0]        groupEvt;
  logic [3:0][7:0]        groupFlags;
  logic [7:0]             regSelRd;
  logic [7:0]             regSelWr;
  logic [7:0]             rdValue;
  logic                   wrStb;
  logic [7:0]             wrData;

  // one-hot register select: bits 3..0 enables, bits 7..4 flags
  function automatic logic [7:0] regSel(input logic [`IEF_ADDR_W-1:0] addr);
    logic [`IEF_IDX_W-1:0] idx;
    idx = addr[`IEF_ADDR_W-1:`IEF_ADDR_LSB];
    regSel = 8'h00;
    case (idx)
      `IEF_IDX_CLKSW_EN:  regSel = 8'h01;
      `IEF_IDX_SER_EN:    regSel = 8'h02;
      `IEF_IDX_KEY_EN:    regSel = 8'h04;
      `IEF_IDX_TMR_EN:    regSel = 8'h08;
      `IEF_IDX_CLKSW_FLG: regSel = 8'h10;
      `IEF_IDX_SER_FLG:   regSel = 8'h20;
      `IEF_IDX_KEY_FLG:   regSel = 8'h40;
      `IEF_IDX_TMR_FLG:   regSel = 8'h80;
      default:            regSel = 8'h00;
    endcase
  endfunction

  // gather the source events into register bit order
  always_comb begin
    groupEvt = '0;
    groupEvt[0][`IEF_BIT_CT1]   = clkTimerEvt[0];
    groupEvt[0][`IEF_BIT_CT2]   = clkTimerEvt[1];
    groupEvt[0][`IEF_BIT_CT8]   = clkTimerEvt[2];
    groupEvt[0][`IEF_BIT_CT32]  = clkTimerEvt[3];
    groupEvt[0][`IEF_BIT_SW1]   = stopwatchEvt[0];
    groupEvt[0][`IEF_BIT_SW10]  = stopwatchEvt[1];
    groupEvt[0][`IEF_BIT_SW100] = stopwatchEvt[2];
    groupEvt[1][`IEF_BIT_S0TX]  = ser0Evt[0];
    groupEvt[1][`IEF_BIT_S0RX]  = ser0Evt[1];
    groupEvt[1][`IEF_BIT_S0ERR] = ser0Evt[2];
    groupEvt[1][`IEF_BIT_S1TX]  = ser1Evt[0];
    groupEvt[1][`IEF_BIT_S1RX]  = ser1Evt[1];
    groupEvt[1][`IEF_BIT_S1ERR] = ser1Evt[2];
    groupEvt[2]                 = keyLineEvt;
    for (int n = 0; n < `IEF_TIMERS; n++) begin
      groupEvt[3][2*n]   = progTimerUflowEvt[n];
      groupEvt[3][2*n+1] = progTimerCmpEvt[n];
    end
  end

  assign regSelRd = regSel(avs_address);
  assign regSelWr = regSel(avs_address);
  assign wrData   = avs_writedata[7:0];

  ief_avmm_slave u_bus (
    .core_clk        (core_clk),
    .sys_rst         (sys_rst),
    .avs_read        (avs_read),
    .avs_write       (avs_write),
    .avs_byteenable  (avs_byteenable),
    .rdValue         (rdValue),
    .avs_waitrequest (avs_waitrequest),
    .avs_readdata    (avs_readdata),
    .wrStb           (wrStb)
  );

  genvar g;
  generate
    for (g = 0; g < `IEF_GROUPS; g++) begin : gen_flags
      ief_flag_reg #(
        .VALID_MASK (GROUP_MASK[g])
      ) u_flag (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .setEvt   (groupEvt[g]),
        .clrStb   (wrStb && regSelWr[4+g]),
        .clrData  (wrData),
        .flags    (groupFlags[g])
      );
    end
  endgenerate

  // read mux; unmapped addresses read zero
  always_comb begin
    rdValue = 8'h00;
    for (int i = 0; i < `IEF_GROUPS; i++) begin
      if (regSelRd[i]) begin
        rdValue = cur_ff.enables[i];
      end
      if (regSelRd[4+i]) begin
        rdValue = groupFlags[i];
      end
    end
  end

  always_comb begin
    nxt_cur = cur_ff;
    for (int i = 0; i < `IEF_GROUPS; i++) begin
      if (wrStb && regSelWr[i]) begin
        // unimplemented enable bits stay zero
        nxt_cur.enables[i] = wrData & GROUP_MASK[i];
      end
      nxt_cur.irqReq[i] = groupFlags[i] & cur_ff.enables[i];
    end
    nxt_cur.anyIrq = |(groupFlags & cur_ff.enables);
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign clkSwIrqReq     = cur_ff.irqReq[0];
  assign serialIrqReq    = cur_ff.irqReq[1];
  assign keyLineIrqReq   = cur_ff.irqReq[2];
  assign progTimerIrqReq = cur_ff.irqReq[3];
  assign anyIrqReq       = cur_ff.anyIrq;

endmodule

/* test/ief_chk_sva.sv */
module ief_chk (
  input wire logic        core_clk,
  input wire logic        sys_rst,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic        avs_waitrequest,
  input wire logic [31:0] avs_readdata,
  input wire logic [7:0]  keyLineEvt,
  input wire logic [7:0]  clkSwIrqReq,
  input wire logic [7:0]  serialIrqReq,
  input wire logic [7:0]  keyLineIrqReq,
  input wire logic [7:0]  progTimerIrqReq,
  input wire logic        anyIrqReq
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  wire logic req = avs_read || avs_write;
  a_wait_one: assert property (req && avs_waitrequest |=> !avs_waitrequest)
    else $error("no answer after one wait cycle");
  a_wait_idle: assert property (!req |=> avs_waitrequest)
    else $error("answer without request");
  a_read_pad: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
    else $error("upper read data not zero");
  a_any_or: assert property (anyIrqReq == |{clkSwIrqReq, serialIrqReq, keyLineIrqReq,
    progTimerIrqReq}) else $error("summary request mismatch");
  a_rsv_zero: assert property (!clkSwIrqReq[7] && serialIrqReq[7:6] == 2'h0)
    else $error("request on unused bit");
  a_rst_quiet: assert property ($past(sys_rst) |-> !anyIrqReq && keyLineIrqReq == 8'h00)
    else $error("request right after reset");
  a_fall_cause: assert property ($fell(anyIrqReq) |-> $past(avs_write, 2))
    else $error("request dropped without write");
  a_rise_cause: assert property ((keyLineIrqReq & ~$past(keyLineIrqReq)) != 8'h00 |->
    $past(keyLineEvt, 2) != 8'h00 || $past(avs_write, 2)) else $error("key request no cause");
  cover property (avs_write && !avs_waitrequest);
  cover property (avs_read && !avs_waitrequest);
  cover property ($rose(anyIrqReq));
endmodule

bind ief_irq_enable_flag_bank ief_chk u_chk (.core_clk, .sys_rst, .avs_read, .avs_write,
  .avs_waitrequest, .avs_readdata, .keyLineEvt, .clkSwIrqReq, .serialIrqReq, .keyLineIrqReq,
  .progTimerIrqReq, .anyIrqReq);

/* test/ief_cpu_model.sv */
module ief_cpu_model (
  input  wire logic        core_clk,
  input  wire logic        avs_waitrequest,
  input  wire logic [31:0] avs_readdata,
  output logic      [17:0] avs_address,
  output logic             avs_read,
  output logic             avs_write,
  output logic      [31:0] avs_writedata
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    avs_address = 18'h00000;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h00000000;
  end
  // one access; called just after a rising edge, returns just after one
  task automatic xfer(input logic w, input logic [15:0] idx, input logic [7:0] d,
                      output logic [7:0] q);
    avs_address <= {idx, 2'h0};
    avs_read <= !w;
    avs_write <= w;
    avs_writedata <= {24'h000000, d};
    do @(posedge core_clk); while (avs_waitrequest);
    q = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    // released lines do not keep the last value
    avs_address <= ~avs_address;
    avs_writedata <= ~avs_writedata;
    @(posedge core_clk);
  endtask
endmodule

/* test/tb_irq_enable_flag_bank.sv */
`include "ief_consts.svh"
module tb_irq_enable_flag_bank;
  timeunit 1ns;
  timeprecision 100ps;
  logic        core_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [28:0] evt = 29'h0;
  logic [3:0]  be = 4'hF;
  logic [17:0] avs_address;
  logic        avs_read;
  logic        avs_write;
  logic        avs_waitrequest;
  logic        anyIrq;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic [7:0]  irq [4];
  int          miscompares = 0;
  int          checked = 0;
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin miscompares++; \
  $display("Error %0t: got %h want %h", $time, a, e); end end
  always #5 core_clk = ~core_clk;
  ief_irq_enable_flag_bank dut_u (.core_clk, .sys_rst, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable(be), .avs_readdata, .avs_waitrequest,
    .clkTimerEvt(evt[3:0]), .stopwatchEvt(evt[6:4]), .ser0Evt(evt[9:7]), .ser1Evt(evt[12:10]),
    .keyLineEvt(evt[20:13]), .progTimerUflowEvt(evt[24:21]), .progTimerCmpEvt(evt[28:25]),
    .clkSwIrqReq(irq[0]), .serialIrqReq(irq[1]), .keyLineIrqReq(irq[2]),
    .progTimerIrqReq(irq[3]), .anyIrqReq(anyIrq));
  ief_cpu_model cpu (.core_clk, .avs_waitrequest, .avs_readdata, .avs_address, .avs_read,
    .avs_write, .avs_writedata);
  task automatic rc(input logic [15:0] a, input logic [7:0] e);
    logic [7:0] q;
    cpu.xfer(1'b0, a, 8'h00, q);
    `CHK(q, e)
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    logic [7:0] q;
    cpu.xfer(1'b1, a, d, q);
  endtask
  task automatic pulse(input logic [28:0] v);
    evt <= v;
    @(posedge core_clk);
    evt <= 29'h0;
  endtask
  task automatic reset_dut;
    sys_rst <= 1'b1;
    repeat (3) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic init_chk;
    for (logic [15:0] a = 16'hFF22; a < 16'hFF26; a++) begin
      rc(a, 8'h00);
      rc(a + 16'h4, 8'h00);
    end
  endtask
  task automatic wrap_up;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    #100000;
    miscompares++;
    wrap_up();
  end
  initial begin
    logic [3:0][7:0] mk;
    logic [15:0]     g;
    logic [7:0]      m;
    int              b;
    mk = {8'hFF, 8'hFF, `IEF_MASK_SER, `IEF_MASK_CLKSW};
    reset_dut();
    init_chk();
    for (logic [15:0] a = 16'hFF22; a < 16'hFF26; a++) begin
      wr(a, 8'hFF);
      rc(a, mk[a[1:0] - 2'h2]);
      wr(a, 8'h00);
    end
    // a write with the low byte lane off must not land
    be <= 4'hE;
    wr(16'hFF24, 8'hFF);
    be <= 4'hF;
    rc(16'hFF24, 8'h00);
    wr(16'hFF2A, 8'hFF);
    rc(16'hFF2A, 8'h00);
    $display("test registers done");
    // each source: flag position, enable gating, write-zero keep, write-one clear
    for (int i = 0; i < 29; i++) begin
      g = 16'((i < 7) ? 0 : (i < 13) ? 1 : (i < 21) ? 2 : 3);
      b = (i < 7) ? i : (i < 13) ? i - 7 : (i < 21) ? i - 13 :
          (i < 25) ? 2 * (i - 21) : 2 * (i - 25) + 1;
      m = 8'h01 << b;
      pulse(29'h1 << i);
      rc(16'hFF26 + g, m);
      `CHK(irq[g], 8'h00)
      wr(16'hFF22 + g, m);
      @(negedge core_clk);
      `CHK(irq[g], m)
      `CHK(anyIrq, 1'b1)
      @(posedge core_clk);
      wr(16'hFF26 + g, ~m);
      rc(16'hFF26 + g, m);
      wr(16'hFF26 + g, m);
      rc(16'hFF26 + g, 8'h00);
      `CHK(irq[g], 8'h00)
      wr(16'hFF22 + g, 8'h00);
    end
    $display("test sources done");
    pulse(29'h1FFFFFFF);
    for (logic [15:0] a = 16'hFF22; a < 16'hFF26; a++) wr(a, 8'hFF);
    reset_dut();
    init_chk();
    `CHK(anyIrq, 1'b0)
    $display("test reset done");
    wrap_up();
  end
endmodule
